// ===== rtl/lio_pkg.sv
// constants shared by the logical input/output bank
package lio_pkg;
	localparam int    NUM_INPUTS        = 32;
	localparam int    NUM_OUTPUTS       = 64;
	localparam int    CLK_HZ            = 20000000;
	localparam int    PULSE_US          = 5000;
	localparam int    TICK_US           = 1000;
	localparam int    TICK_CYCLES       = TICK_US * (CLK_HZ / 1000000);
	localparam int    PULSE_TICKS       = PULSE_US / TICK_US;
	localparam int    TS_W              = 32;
	localparam int    IDX_W             = 6;
	localparam logic [1:0] GROUP_LOW    = 2'h1;
	localparam logic [1:0] GROUP_HIGH   = 2'h3;
	localparam logic [NUM_INPUTS-1:0] INPUT_RESET = 32'h00000000;
	localparam logic [NUM_OUTPUTS-1:0] OUTPUT_RESET = 64'h0000000000000000;
endpackage : lio_pkg

// ===== rtl/lio_tick.sv
// divider producing a one-cycle tick every TICK_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module lio_tick
	import lio_pkg::*;
#(
	parameter int DIV = TICK_CYCLES
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// tick out
	output var  logic tick
);
	initial begin
		if (DIV < 2) $error("divider too small");
	end

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} tick_s;

	tick_s st_q;
	tick_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt == 32'(DIV - 1)) begin
			st_d.cnt  = 32'h00000000;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 32'h00000001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;
endmodule : lio_tick
`default_nettype wire

// ===== rtl/lio_bank.sv
// logical input hold/pulse bank and logical output event generator
// Behaviour
// - thirty-two independent logical input status bits
// - every input status clears to 0 on reset
// - hold mode: command 1 sets, stays until command 0 or reset
// - pulse mode: command 1 sets, clears itself after 5 ms
// - sixty-four logical outputs carrying user logic results
// - each output change raises an ON or OFF event
// - per-direction enables pick ON, OFF or both; others dropped
// - each stored event carries the time stamp of the last enabled change on its output
// - outputs 1-32 use low group code, 33-64 high group code
`timescale 1ns/1ps
`default_nettype none
module lio_bank
	import lio_pkg::*;
#(
	parameter int NI = NUM_INPUTS,
	parameter int NO = NUM_OUTPUTS,
	parameter int TICK_DIV = TICK_CYCLES
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// input commands, one per source
	input  wire logic          panel_cmd_valid,
	input  wire logic [4:0]    panel_cmd_index,
	input  wire logic          panel_cmd_value,
	input  wire logic          link_cmd_valid,
	input  wire logic [4:0]    link_cmd_index,
	input  wire logic          link_cmd_value,
	// per-input mode, 1 = pulse
	input  wire logic [NI-1:0] pulse_mode,
	// logical input status
	output var  logic [NI-1:0] input_status,
	// logical outputs from user logic
	input  wire logic [NO-1:0] user_logic,
	input  wire logic          event_on_enable,
	input  wire logic          event_off_enable,
	output var  logic [NO-1:0] logical_output,
	// event stream
	output var  logic          event_valid,
	output var  logic          event_is_on,
	output var  logic [IDX_W-1:0] event_index,
	output var  logic [1:0]    event_group,
	output var  logic [TS_W-1:0] event_time,
	// free-running time stamp
	output var  logic [TS_W-1:0] time_stamp
);
	initial begin
		if (NI != 32 || NO != 64) $error("bank sizes must be 32 inputs and 64 outputs");
	end

	typedef struct packed {
		logic [NI-1:0]     stat;
		logic [NI-1:0][2:0] ptick;
		logic [NO-1:0]     outs;
		logic [NO-1:0]     pend_on;
		logic [NO-1:0]     pend_off;
		logic [NO-1:0][TS_W-1:0] pend_ts;
		logic              ev_valid;
		logic              ev_on;
		logic [IDX_W-1:0]  ev_idx;
		logic [1:0]        ev_grp;
		logic [TS_W-1:0]   ev_ts;
		logic [TS_W-1:0]   ts;
	} bank_s;

	bank_s st_q;
	bank_s st_d;
	logic  tick;

	lio_tick #(.DIV(TICK_DIV)) u_tick (
		.mclk (mclk),
		.rst  (rst),
		.tick (tick)
	);

	function automatic logic [1:0] group_of(input logic [IDX_W-1:0] idx);
		group_of = idx[5] ? GROUP_HIGH : GROUP_LOW;
	endfunction : group_of

	always_comb begin
		logic found;
		logic v;
		found = 1'b0;
		v     = 1'b0;
		st_d = st_q;
		st_d.ts = st_q.ts + 32'h00000001;
		// pulse timers count ticks down to expiry
		for (int i = 0; i < NI; i++) begin
			if (tick && st_q.ptick[i] != 3'h0) begin
				st_d.ptick[i] = st_q.ptick[i] - 3'h1;
				if (st_q.ptick[i] == 3'h1) st_d.stat[i] = 1'b0;
			end
		end
		// commands: link value selected over panel value so link wins on a clash
		for (int i = 0; i < NI; i++) begin
			if ((panel_cmd_valid && panel_cmd_index == 5'(i)) ||
			    (link_cmd_valid && link_cmd_index == 5'(i))) begin
				v = (link_cmd_valid && link_cmd_index == 5'(i)) ? link_cmd_value
				                                                 : panel_cmd_value;
				if (v) begin
					st_d.stat[i] = 1'b1;
					// pulse rounds up: one extra tick covers the partial first period
					st_d.ptick[i] = pulse_mode[i] ? 3'(PULSE_TICKS + 1) : 3'h0;
				end else begin
					st_d.stat[i]  = 1'b0;
					st_d.ptick[i] = 3'h0;
				end
			end
		end
		// output change detection with time-stamped pending events
		st_d.outs = user_logic;
		for (int j = 0; j < NO; j++) begin
			if (user_logic[j] && !st_q.outs[j] && event_on_enable) begin
				st_d.pend_on[j] = 1'b1;
				st_d.pend_ts[j] = st_q.ts;
			end
			if (!user_logic[j] && st_q.outs[j] && event_off_enable) begin
				st_d.pend_off[j] = 1'b1;
				st_d.pend_ts[j] = st_q.ts;
			end
		end
		// emit lowest pending event, one per cycle
		st_d.ev_valid = 1'b0;
		for (int j = 0; j < NO; j++) begin
			if (!found && (st_q.pend_on[j] || st_q.pend_off[j])) begin
				found = 1'b1;
				st_d.ev_valid = 1'b1;
				st_d.ev_on  = st_q.pend_on[j];
				st_d.ev_idx = IDX_W'(j);
				st_d.ev_grp = group_of(IDX_W'(j));
				st_d.ev_ts  = st_q.pend_ts[j];
				// a fresh change in this cycle keeps its flag set
				if (st_q.pend_on[j]) begin
					st_d.pend_on[j] = user_logic[j] && !st_q.outs[j] && event_on_enable;
				end else begin
					st_d.pend_off[j] = !user_logic[j] && st_q.outs[j] && event_off_enable;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= '0;
			st_q.stat <= INPUT_RESET;
			st_q.outs <= OUTPUT_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		input_status   = st_q.stat;
		logical_output = st_q.outs;
		event_valid    = st_q.ev_valid;
		event_is_on    = st_q.ev_on;
		event_index    = st_q.ev_idx;
		event_group    = st_q.ev_grp;
		event_time     = st_q.ev_ts;
		time_stamp     = st_q.ts;
	end

	// helper: cycles input 0 has stood high since its last 1 command in pulse mode
	logic        cmd0_hit;
	logic        cmd0_val;
	logic [31:0] hi_cnt_q;
	assign cmd0_hit = (link_cmd_valid && link_cmd_index == 5'h00) ||
	                  (panel_cmd_valid && panel_cmd_index == 5'h00);
	assign cmd0_val = (link_cmd_valid && link_cmd_index == 5'h00) ? link_cmd_value
	                                                               : panel_cmd_value;
	always_ff @(posedge mclk) begin
		if (rst || !st_q.stat[0] || !pulse_mode[0] || (cmd0_hit && cmd0_val)) begin
			hi_cnt_q <= 32'h00000000;
		end else begin
			hi_cnt_q <= hi_cnt_q + 32'h00000001;
		end
	end

	sequence s_set1;
		link_cmd_valid && link_cmd_value && !panel_cmd_valid;
	endsequence

	a_reset_clears: assert property (@(posedge mclk)
		rst |=> input_status == '0 && !event_valid)
		else $error("reset did not clear status");
	a_hold_set: assert property (@(posedge mclk) disable iff (rst)
		s_set1 |=> input_status[$past(link_cmd_index)])
		else $error("command 1 did not set input");
	a_cmd_clear: assert property (@(posedge mclk) disable iff (rst)
		link_cmd_valid && !link_cmd_value |=> !input_status[$past(link_cmd_index)])
		else $error("command 0 did not clear input");
	a_hold_stays: assert property (@(posedge mclk) disable iff (rst)
		!pulse_mode[0] && input_status[0] && !cmd0_hit |=> input_status[0])
		else $error("hold input dropped by itself");
	a_pulse_bound: assert property (@(posedge mclk) disable iff (rst)
		hi_cnt_q <= 32'(TICK_DIV * (PULSE_TICKS + 1)))
		else $error("pulse input stayed high too long");
	a_pulse_min: assert property (@(posedge mclk) disable iff (rst)
		pulse_mode[0] && $fell(input_status[0]) && !$past(rst) && !$past(cmd0_hit && !cmd0_val)
		|-> hi_cnt_q >= 32'(TICK_DIV * PULSE_TICKS))
		else $error("pulse input fell too early");
	a_out_follows: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> logical_output == $past(user_logic))
		else $error("logical output not following user logic");
	a_on_event: assert property (@(posedge mclk) disable iff (rst)
		event_valid && event_is_on |-> event_on_enable || $past(event_on_enable, 2))
		else $error("on event while on events disabled");
	a_event_group: assert property (@(posedge mclk) disable iff (rst)
		event_valid |-> event_group == (event_index < 6'h20 ? GROUP_LOW : GROUP_HIGH))
		else $error("event group code wrong");
	a_stamp_past: assert property (@(posedge mclk) disable iff (rst)
		event_valid |-> event_time < time_stamp)
		else $error("event time stamp not earlier than now");
	a_change_event: assert property (@(posedge mclk) disable iff (rst)
		event_on_enable && user_logic[0] && !logical_output[0] |-> ##[1:66]
		(event_valid && event_index == 6'h00))
		else $error("change produced no event");
endmodule : lio_bank
`default_nettype wire

// ===== sim/lio_partner.sv
// partner model: panel switch, supervisory link and user logic
`timescale 1ns/1ps
`default_nettype none
module lio_partner (
	// clock
	input  wire logic        mclk,
	// commands from panel and link
	output var  logic        panel_cmd_valid,
	output var  logic [4:0]  panel_cmd_index,
	output var  logic        panel_cmd_value,
	output var  logic        link_cmd_valid,
	output var  logic [4:0]  link_cmd_index,
	output var  logic        link_cmd_value,
	// user logic results
	output var  logic [63:0] user_logic
);
	initial begin
		panel_cmd_valid = 1'b0;
		panel_cmd_index = 5'h00;
		panel_cmd_value = 1'b0;
		link_cmd_valid  = 1'b0;
		link_cmd_index  = 5'h00;
		link_cmd_value  = 1'b0;
		user_logic      = 64'h0000000000000000;
	end
	// one-cycle command; idle fields show the inverse so stale values never match
	task automatic send(input logic link, input logic [4:0] idx, input logic val);
		@(posedge mclk);
		#1;
		if (link) begin
			link_cmd_valid = 1'b1;
			link_cmd_index = idx;
			link_cmd_value = val;
		end else begin
			panel_cmd_valid = 1'b1;
			panel_cmd_index = idx;
			panel_cmd_value = val;
		end
		@(posedge mclk);
		#1;
		panel_cmd_valid = 1'b0;
		panel_cmd_index = ~idx;
		panel_cmd_value = ~val;
		link_cmd_valid  = 1'b0;
		link_cmd_index  = ~idx;
		link_cmd_value  = ~val;
	endtask : send
	// user logic result changes just after an edge
	task automatic drive_user(input logic [63:0] v);
		@(posedge mclk);
		#1;
		user_logic = v;
	endtask : drive_user
endmodule : lio_partner
`default_nettype wire

// ===== sim/logical_io_hold_pulse_bank_bench.sv
// self-checking bench for the logical input/output bank
`timescale 1ns/1ps
`default_nettype none
module logical_io_hold_pulse_bank_bench;
	import lio_pkg::*;
	logic mclk = 1'b0;
	logic rst, on_en, off_en;
	logic [31:0] pulse_mode;
	logic pv, pvl, lv, lvl;
	logic [4:0] pi, li;
	logic [63:0] ul, lo;
	logic [31:0] st, ets, ts, t0;
	logic ev, eon;
	logic [5:0] eidx;
	logic [1:0] egrp;
	int n_fail = 0, n_checks = 0;
	always #25 mclk = ~mclk;
	lio_partner p (.mclk(mclk), .panel_cmd_valid(pv), .panel_cmd_index(pi),
		.panel_cmd_value(pvl), .link_cmd_valid(lv), .link_cmd_index(li),
		.link_cmd_value(lvl), .user_logic(ul));
	lio_bank #(.TICK_DIV(4)) dut (.mclk(mclk), .rst(rst), .panel_cmd_valid(pv),
		.panel_cmd_index(pi), .panel_cmd_value(pvl), .link_cmd_valid(lv),
		.link_cmd_index(li), .link_cmd_value(lvl), .pulse_mode(pulse_mode),
		.input_status(st), .user_logic(ul), .event_on_enable(on_en),
		.event_off_enable(off_en), .logical_output(lo), .event_valid(ev),
		.event_is_on(eon), .event_index(eidx), .event_group(egrp),
		.event_time(ets), .time_stamp(ts));
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	// steps n cycles and reports whether an event showed in any of them
	task automatic quiet(input int n, output logic any);
		any = 1'b0;
		repeat (n) begin
			cyc(1);
			any = any | ev;
		end
	endtask : quiet
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	// waits a bounded time for the next event and judges its fields
	task automatic ev_check(input logic [5:0] idx, input logic on, input logic [31:0] tc);
		int k;
		for (k = 0; k < 8 && ev !== 1'b1; k++) cyc(1);
		chk("event_valid", ev, 1'b1);
		chk("event_is_on", eon, on);
		chk("event_index", eidx, idx);
		chk("event_group", egrp, idx < 6'h20 ? GROUP_LOW : GROUP_HIGH);
		chk("event_time", ets, tc);
		cyc(1);
	endtask : ev_check
	task automatic t_reset;
		chk("status_reset", st, INPUT_RESET);
		chk("output_reset", lo, OUTPUT_RESET);
		chk("event_reset", ev, 1'b0);
		chk("stamp_reset", ts, 32'h00000000);
		cyc(5);
		chk("stamp_runs", ts, 32'h00000005);
		$display("test reset done");
	endtask : t_reset
	task automatic t_hold;
		p.send(1'b1, 5'h1F, 1'b1);
		chk("hold_set", st, 32'h80000000);
		p.send(1'b0, 5'h00, 1'b1);
		cyc(30);
		chk("hold_stays", st, 32'h80000001);
		p.send(1'b0, 5'h1F, 1'b0);
		chk("hold_clear", st, 32'h00000001);
		cyc(1);
		rst = 1'b1;
		cyc(1);
		rst = 1'b0;
		chk("restart_clear", st, INPUT_RESET);
		chk("restart_stamp", ts, 32'h00000000);
		$display("test hold done");
	endtask : t_hold
	task automatic t_pulse;
		pulse_mode = 32'h00000001;
		p.send(1'b1, 5'h00, 1'b1);
		chk("pulse_set", st, 32'h00000001);
		cyc(18);
		chk("pulse_holds", st, 32'h00000001);
		cyc(7);
		chk("pulse_ends", st, 32'h00000000);
		p.send(1'b0, 5'h00, 1'b1);
		chk("pulse_panel", st, 32'h00000001);
		cyc(10);
		p.send(1'b1, 5'h00, 1'b1);
		cyc(18);
		chk("pulse_restart", st, 32'h00000001);
		cyc(7);
		chk("pulse_restart_end", st, 32'h00000000);
		$display("test pulse done");
	endtask : t_pulse
	task automatic t_events;
		logic q;
		on_en = 1'b1;
		off_en = 1'b0;
		p.drive_user(64'h0000010000000001);
		t0 = ts;
		ev_check(6'h00, 1'b1, t0);
		ev_check(6'h28, 1'b1, t0);
		chk("logical_output", lo, 64'h0000010000000001);
		p.drive_user(64'h0000000000000001);
		quiet(6, q);
		chk("off_dropped", q, 1'b0);
		off_en = 1'b1;
		on_en = 1'b0;
		p.drive_user(64'h0000000000000000);
		t0 = ts;
		ev_check(6'h00, 1'b0, t0);
		p.drive_user(64'h8000000000000000);
		quiet(6, q);
		chk("on_dropped", q, 1'b0);
		on_en = 1'b1;
		p.drive_user(64'h0000000000000000);
		t0 = ts;
		ev_check(6'h3F, 1'b0, t0);
		$display("test events done");
	endtask : t_events
	initial begin
		#(60000 * 50);
		n_fail++;
		final_report();
	end
	initial begin
		rst        = 1'b1;
		on_en      = 1'b1;
		off_en     = 1'b1;
		pulse_mode = 32'h00000000;
		cyc(6);
		rst = 1'b0;
		t_reset();
		t_hold();
		t_pulse();
		t_events();
		final_report();
	end
endmodule : logical_io_hold_pulse_bank_bench
`default_nettype wire
